// [hdl/regprot_pkg.sv]
package regprot_pkg;
	// Protection timing, in switching cycles.
	localparam logic [2:0] LIMIT_RUN_COUNT = 3'h5;
	localparam logic [4:0] BLANK_CYCLES = 5'h10;
	// Switching phase step on the oscillator: one period of ten slots; 216 degrees is six.
	localparam logic [3:0] PHASE_SLOTS = 4'h9;
	localparam logic [3:0] SECOND_BUCK_SHIFT = 4'h6;
	// Frequency code range: sixteen steps between 0.8 and 1.0 times nominal.
	localparam logic [3:0] FREQ_CODE_MAX = 4'hF;
	localparam logic [3:0] FREQ_CODE_RESET = 4'hF;
	localparam logic [4:0] LFSR_SEED = 5'h1;
	// Reset hold time and its count at 50 MHz.
	localparam int RESET_HOLD_US = 10;
	localparam int CLOCK_MHZ = 50;
	localparam int RESET_HOLD_CYCLES = RESET_HOLD_US * CLOCK_MHZ;
	// Auxiliary supply switch-over thresholds in millivolts.
	localparam logic [15:0] AUX_ON_MV = 16'h12C0;
	localparam logic [15:0] AUX_OFF_MV = 16'h11F8;
endpackage : regprot_pkg

// [hdl/cycle_sync_if.sv]
`timescale 1ns/1ns
interface cycle_sync_if;
	logic cycleStart;
	logic atStart;
	modport source (output cycleStart, output atStart);
	modport sink (input cycleStart, input atStart);
endinterface : cycle_sync_if

// [hdl/limit_blanker.sv]
`timescale 1ns/1ns
// Counts cycles whose current limit trips at cycle start and blanks PWM for sixteen cycles.
module limit_blanker (
	input wire logic ref_clk,
	input wire logic reset,
	cycle_sync_if.sink sync,
	input wire logic limitHit,
	input wire logic forceBlank,
	output logic blanking
);
	logic [2:0] runCount;
	logic [4:0] blankCount;
	logic [2:0] next_runCount;
	logic [4:0] next_blankCount;

	always_comb
	begin
		next_runCount = runCount;
		next_blankCount = blankCount;
		if (blankCount != 5'h00)
		begin
			if (sync.cycleStart)
			begin
				next_blankCount = blankCount - 5'h01;
				if (blankCount == 5'h01)
				begin
					next_runCount = 3'h0; // R22
				end
			end
		end
		else if (forceBlank)
		begin
			next_blankCount = regprot_pkg::BLANK_CYCLES; // R4
			next_runCount = 3'h0;
		end
		else if (sync.atStart && limitHit)
		begin
			if (runCount == regprot_pkg::LIMIT_RUN_COUNT - 3'h1)
			begin
				next_blankCount = regprot_pkg::BLANK_CYCLES; // R2 R7
				next_runCount = 3'h0;
			end
			else
			begin
				next_runCount = runCount + 3'h1;
			end
		end
		else if (sync.atStart)
		begin
			next_runCount = 3'h0; // R22
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			runCount <= 3'h0;
			blankCount <= 5'h00;
		end
		else
		begin
			runCount <= next_runCount;
			blankCount <= next_blankCount;
		end
	end

	assign blanking = (blankCount != 5'h00);
endmodule : limit_blanker

// [hdl/spread_stepper.sv]
`timescale 1ns/1ns
// Steps the oscillator frequency code once per main buck cycle.
module spread_stepper (
	input wire logic ref_clk,
	input wire logic reset,
	cycle_sync_if.sink sync,
	input wire logic spreadEnable,
	input wire logic triangleMode,
	output logic [3:0] freqCode
);
	logic [4:0] lfsr;
	logic [3:0] code;
	logic goingUp;
	logic [4:0] next_lfsr;
	logic [3:0] next_code;
	logic next_goingUp;

	always_comb
	begin
		next_lfsr = lfsr;
		next_code = code;
		next_goingUp = goingUp;
		if (!spreadEnable)
		begin
			next_code = regprot_pkg::FREQ_CODE_RESET;
		end
		else if (sync.cycleStart)
		begin
			if (triangleMode)
			begin
				if (goingUp && code == regprot_pkg::FREQ_CODE_MAX)
				begin
					next_goingUp = 1'b0;
					next_code = code - 4'h1; // R11
				end
				else if (!goingUp && code == 4'h0)
				begin
					next_goingUp = 1'b1;
					next_code = 4'h1;
				end
				else
				begin
					next_code = goingUp ? code + 4'h1 : code - 4'h1; // R11
				end
			end
			else
			begin
				next_lfsr = {lfsr[3:0], lfsr[4] ^ lfsr[2]}; // R10
				// The random bit only picks direction, so the code moves one step.
				if (lfsr[4] && code != regprot_pkg::FREQ_CODE_MAX)
				begin
					next_code = code + 4'h1; // R10
				end
				else if (!lfsr[4] && code != 4'h0)
				begin
					next_code = code - 4'h1; // R10
				end
				else
				begin
					next_code = lfsr[4] ? code - 4'h1 : code + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			lfsr <= regprot_pkg::LFSR_SEED;
			code <= regprot_pkg::FREQ_CODE_RESET;
			goingUp <= 1'b0;
		end
		else
		begin
			lfsr <= next_lfsr;
			code <= next_code;
			goingUp <= next_goingUp;
		end
	end

	assign freqCode = code; // R12
endmodule : spread_stepper

// [hdl/regulator_protect_and_reset_ctrl.sv]
`timescale 1ns/1ns
// Behaviour
// R1: Buck high-side limit turns high-side off, low-side on, for rest of cycle.
// R2: Five consecutive start-of-cycle buck limits force PWM low sixteen cycles.
// R3: Buck low-side limit turns low-side off until cycle end.
// R4: Low-side limit just after blanking turns both buck switches off sixteen cycles.
// R5: Third buck in phase with main buck; second buck 216 degrees later (code starts second buck on odd slots, one slot after third buck).
// R6: Boost in phase with main buck; pulse skipping at low load.
// R7: Boost limit ends cycle; five start-of-cycle limits blank sixteen cycles.
// R8: Boost out of window: switch off, set failure flag; enable restarts.
// R9: Boost overtemperature: off, flag set; restart needs flag clear and enable.
// R10: Pseudo-random code from a shift register moves one step per cycle.
// R11: Triangular spreading uses an up-down counter.
// R12: Spreading changes frequency each main cycle over sixteen codes.
// R13: Second buck sees 31 frequencies as oscillator changes mid-period.
// R14: Linear regulator overtemperature: off, flag; restart needs flag clear and enable.
// R15: Linear regulator out of window: off, failure flag; enable restarts.
// R16: Linear regulator overvoltage in check or ramp mode: protection off, error.
// R17: Gate supply uses auxiliary input above 4.8 V, only once active.
// R18: Processor reset held low for the hold time after any trigger.
// R19: Processor reset asserted also asserts peripheral reset.
// R20: Peripheral reset latched until first watchdog trigger rising edge.
// R21: Reset outputs stay low under low supply or shutdown.
// R22: Limit run counter clears on a clean cycle start or blanking end.
module regulator_protect_and_reset_ctrl (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic oscTick,
	input wire logic mainPwm,
	input wire logic secondPwm,
	input wire logic thirdPwm,
	input wire logic boostPwm,
	input wire logic lowLoad,
	input wire logic secondHsLimit,
	input wire logic thirdHsLimit,
	input wire logic secondLsLimit,
	input wire logic thirdLsLimit,
	input wire logic secondLsEarly,
	input wire logic thirdLsEarly,
	input wire logic boostLimit,
	input wire logic boostWindowFault,
	input wire logic boostOvertemp,
	input wire logic boostEnableWrite,
	input wire logic linregOvertemp,
	input wire logic linregWindowFault,
	input wire logic linregOvervoltage,
	input wire logic linregEnableWrite,
	input wire logic threshold_check_mode,
	input wire logic rampMode,
	input wire logic activeMode,
	input wire logic [15:0] auxSupplyMv,
	input wire logic spreadEnable,
	input wire logic triangleMode,
	input wire logic resetTrigger,
	input wire logic watchdog_trigger_in,
	output logic secondHsOn,
	output logic secondLsOn,
	output logic thirdHsOn,
	output logic thirdLsOn,
	output logic boostSwitchOn,
	output logic boostRunning,
	output logic boostFailFlag,
	output logic boost_overtemp_flag,
	output logic linregRunning,
	output logic linreg_failure_flag,
	output logic linreg_overtemp_flag,
	output logic external_protection_switch,
	output logic errorRequest,
	output logic useAuxSupply,
	output logic [3:0] freqCode,
	output logic processor_reset_out_n,
	output logic peripheral_reset_out_n
);
	localparam int HOLD_CYCLES = regprot_pkg::RESET_HOLD_CYCLES;
	cycle_sync_if mainSync ();
	cycle_sync_if secondSync ();
	cycle_sync_if thirdSync ();
	cycle_sync_if boostSync ();
	logic [3:0] phase;
	logic [3:0] next_phase;
	logic wdMeta;
	logic wdSync;
	logic wdLast;
	logic secondBlank;
	logic thirdBlank;
	logic boostBlank;
	logic secondHsCut;
	logic secondLsCut;
	logic thirdHsCut;
	logic thirdLsCut;
	logic boostCut;
	logic next_secondHsCut;
	logic next_secondLsCut;
	logic next_thirdHsCut;
	logic next_thirdLsCut;
	logic next_boostCut;
	logic next_boostRunning;
	logic next_boostFailFlag;
	logic next_boostOt;
	logic next_linregRunning;
	logic next_linregFail;
	logic next_linregOt;
	logic next_protSwitch;
	logic next_error;
	logic next_useAux;
	logic [9:0] holdCount;
	logic [9:0] next_holdCount;
	logic next_procReset;
	logic next_periphReset;

	// Oscillator slots: main buck and boost run on ten-slot and two-slot periods.
	always_comb
	begin
		next_phase = (phase == regprot_pkg::PHASE_SLOTS) ? 4'h0 : phase + 4'h1;
		if (!oscTick)
		begin
			next_phase = phase;
		end
	end

	assign mainSync.cycleStart = oscTick && (phase == 4'h0);
	assign mainSync.atStart = mainSync.cycleStart;
	assign thirdSync.cycleStart = oscTick && !phase[0]; // R5
	assign thirdSync.atStart = thirdSync.cycleStart;
	// Bit 0 of the shift is even, plus one selects odd slots: second buck starts one slot after the third buck.
	assign secondSync.cycleStart = oscTick && (phase[0] == regprot_pkg::SECOND_BUCK_SHIFT[0] + 1'b1); // R5 R13
	assign secondSync.atStart = secondSync.cycleStart;
	assign boostSync.cycleStart = thirdSync.cycleStart; // R6
	assign boostSync.atStart = boostSync.cycleStart;

	limit_blanker secondBlanker (
		.ref_clk(ref_clk),
		.reset(reset),
		.sync(secondSync),
		.limitHit(secondHsLimit),
		.forceBlank(secondLsEarly && secondLsLimit), // R4
		.blanking(secondBlank)
	);
	limit_blanker thirdBlanker (
		.ref_clk(ref_clk),
		.reset(reset),
		.sync(thirdSync),
		.limitHit(thirdHsLimit),
		.forceBlank(thirdLsEarly && thirdLsLimit), // R4
		.blanking(thirdBlank)
	);
	limit_blanker boostBlanker (
		.ref_clk(ref_clk),
		.reset(reset),
		.sync(boostSync),
		.limitHit(boostLimit),
		.forceBlank(1'b0),
		.blanking(boostBlank)
	);
	spread_stepper stepper (
		.ref_clk(ref_clk),
		.reset(reset),
		.sync(mainSync),
		.spreadEnable(spreadEnable),
		.triangleMode(triangleMode),
		.freqCode(freqCode)
	);

	// Per-cycle cut latches clear at each converter's cycle start.
	always_comb
	begin
		next_secondHsCut = secondSync.cycleStart ? 1'b0 : (secondHsCut || secondHsLimit); // R1
		next_secondLsCut = secondSync.cycleStart ? 1'b0 : (secondLsCut || secondLsLimit); // R3
		next_thirdHsCut = thirdSync.cycleStart ? 1'b0 : (thirdHsCut || thirdHsLimit); // R1
		next_thirdLsCut = thirdSync.cycleStart ? 1'b0 : (thirdLsCut || thirdLsLimit); // R3
		next_boostCut = boostSync.cycleStart ? 1'b0 : (boostCut || boostLimit); // R7
	end

	// Boost and linear regulator supervision; a fault wins over a restart write.
	always_comb
	begin
		next_boostFailFlag = boostFailFlag;
		next_boostOt = boost_overtemp_flag || boostOvertemp;
		next_boostRunning = boostRunning;
		if (boostWindowFault)
		begin
			next_boostFailFlag = 1'b1; // R8
			next_boostRunning = 1'b0;
		end
		else if (boostOvertemp)
		begin
			next_boostRunning = 1'b0; // R9
		end
		else if (boostEnableWrite && !boost_overtemp_flag)
		begin
			next_boostRunning = 1'b1; // R8 R9
			next_boostFailFlag = 1'b0;
		end
		next_linregFail = linreg_failure_flag;
		next_linregOt = linreg_overtemp_flag || linregOvertemp;
		next_linregRunning = linregRunning;
		if (linregWindowFault)
		begin
			next_linregFail = 1'b1; // R15
			next_linregRunning = 1'b0;
		end
		else if (linregOvertemp)
		begin
			next_linregRunning = 1'b0; // R14
		end
		else if (linregEnableWrite && !linreg_overtemp_flag)
		begin
			next_linregRunning = 1'b1; // R14 R15
			next_linregFail = 1'b0;
		end
		next_error = linregOvervoltage && (threshold_check_mode || rampMode); // R16
		next_protSwitch = activeMode && !next_error && !errorRequest; // R16
		next_useAux = useAuxSupply;
		if (!activeMode || auxSupplyMv < regprot_pkg::AUX_OFF_MV)
		begin
			next_useAux = 1'b0;
		end
		else if (auxSupplyMv > regprot_pkg::AUX_ON_MV)
		begin
			next_useAux = 1'b1; // R17
		end
	end

	// Reset outputs: a trigger reloads the hold, peripheral reset waits for the watchdog.
	always_comb
	begin
		next_holdCount = holdCount;
		next_procReset = processor_reset_out_n;
		next_periphReset = peripheral_reset_out_n;
		if (resetTrigger)
		begin
			next_holdCount = 10'(HOLD_CYCLES); // R18
			next_procReset = 1'b0;
			next_periphReset = 1'b0; // R19
		end
		else if (holdCount != 10'h000)
		begin
			next_holdCount = holdCount - 10'h001; // R18
		end
		else
		begin
			next_procReset = 1'b1;
			if (wdSync && !wdLast && processor_reset_out_n)
			begin
				next_periphReset = 1'b1; // R20
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			phase <= 4'h0;
			wdMeta <= 1'b0;
			wdSync <= 1'b0;
			wdLast <= 1'b0;
			secondHsCut <= 1'b0;
			secondLsCut <= 1'b0;
			thirdHsCut <= 1'b0;
			thirdLsCut <= 1'b0;
			boostCut <= 1'b0;
			secondHsOn <= 1'b0;
			secondLsOn <= 1'b0;
			thirdHsOn <= 1'b0;
			thirdLsOn <= 1'b0;
			boostSwitchOn <= 1'b0;
			boostRunning <= 1'b0;
			boostFailFlag <= 1'b0;
			boost_overtemp_flag <= 1'b0;
			linregRunning <= 1'b0;
			linreg_failure_flag <= 1'b0;
			linreg_overtemp_flag <= 1'b0;
			external_protection_switch <= 1'b0;
			errorRequest <= 1'b0;
			useAuxSupply <= 1'b0;
			holdCount <= 10'(HOLD_CYCLES);
			processor_reset_out_n <= 1'b0; // R21
			peripheral_reset_out_n <= 1'b0; // R21
		end
		else
		begin
			phase <= next_phase;
			wdMeta <= watchdog_trigger_in;
			wdSync <= wdMeta;
			wdLast <= wdSync;
			secondHsCut <= next_secondHsCut;
			secondLsCut <= next_secondLsCut;
			thirdHsCut <= next_thirdHsCut;
			thirdLsCut <= next_thirdLsCut;
			boostCut <= next_boostCut;
			secondHsOn <= secondPwm && !next_secondHsCut && !secondBlank; // R1 R2
			secondLsOn <= (!secondPwm || next_secondHsCut) && !next_secondLsCut && !secondBlank; // R3 R4
			thirdHsOn <= thirdPwm && !next_thirdHsCut && !thirdBlank; // R1 R2
			thirdLsOn <= (!thirdPwm || next_thirdHsCut) && !next_thirdLsCut && !thirdBlank; // R3 R4
			boostSwitchOn <= boostPwm && boostRunning && !lowLoad && !next_boostCut && !boostBlank; // R6 R7
			boostRunning <= next_boostRunning;
			boostFailFlag <= next_boostFailFlag;
			boost_overtemp_flag <= next_boostOt;
			linregRunning <= next_linregRunning;
			linreg_failure_flag <= next_linregFail;
			linreg_overtemp_flag <= next_linregOt;
			external_protection_switch <= next_protSwitch;
			errorRequest <= next_error;
			useAuxSupply <= next_useAux;
			holdCount <= next_holdCount;
			processor_reset_out_n <= next_procReset;
			peripheral_reset_out_n <= next_periphReset;
		end
	end
endmodule : regulator_protect_and_reset_ctrl

// [sim/regprot_monitor.sv]
`timescale 1ns/1ns
module regprot_monitor (
	input logic ref_clk,
	input logic reset,
	input logic resetTrigger,
	input logic watchdog_trigger_in,
	input logic boostWindowFault,
	input logic boostOvertemp,
	input logic boostEnableWrite,
	input logic linregOvertemp,
	input logic linregWindowFault,
	input logic linregOvervoltage,
	input logic threshold_check_mode,
	input logic rampMode,
	input logic activeMode,
	input logic spreadEnable,
	input logic [3:0] freqCode,
	input logic boostRunning,
	input logic boostFailFlag,
	input logic boost_overtemp_flag,
	input logic linregRunning,
	input logic linreg_failure_flag,
	input logic linreg_overtemp_flag,
	input logic external_protection_switch,
	input logic errorRequest,
	input logic useAuxSupply,
	input logic processor_reset_out_n,
	input logic peripheral_reset_out_n
);
	localparam int HOLD_MIN = regprot_pkg::RESET_HOLD_CYCLES - 1;
	logic [15:0] lowCount;
	logic [15:0] next_lowCount;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Counts how long the processor reset has been held low.
	always_comb next_lowCount = processor_reset_out_n ? 16'h0000 : lowCount + 16'h0001;
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			lowCount <= 16'h0000;
		else
			lowCount <= next_lowCount;
	AST_HOLD: assert property ($rose(processor_reset_out_n) |-> lowCount >= HOLD_MIN)
		else $error("reset hold short");
	AST_TRIGGER: assert property (resetTrigger |=> !processor_reset_out_n)
		else $error("trigger no reset");
	AST_SLAVE: assert property (!processor_reset_out_n |-> !peripheral_reset_out_n)
		else $error("peripheral reset not slaved");
	AST_WD_RELEASE: assert property ($rose(peripheral_reset_out_n) |->
		processor_reset_out_n && $past(watchdog_trigger_in, 2)) else $error("early release");
	AST_BOOST_FAIL: assert property (boostWindowFault |=> boostFailFlag && !boostRunning)
		else $error("boost fail");
	AST_BOOST_OT: assert property (boostOvertemp |=> boost_overtemp_flag && !boostRunning)
		else $error("boost temp");
	AST_BOOST_REFUSE: assert property (boost_overtemp_flag && boostEnableWrite |=> !boostRunning)
		else $error("boost restart hot");
	AST_LIN_OT: assert property (linregOvertemp |=> linreg_overtemp_flag && !linregRunning)
		else $error("linreg temp");
	AST_LIN_FAIL: assert property (linregWindowFault |=> linreg_failure_flag && !linregRunning)
		else $error("linreg fail");
	AST_OVERVOLT: assert property (linregOvervoltage && (threshold_check_mode || rampMode) |=>
		!external_protection_switch && errorRequest) else $error("overvoltage");
	AST_AUX: assert property (!activeMode |=> !useAuxSupply)
		else $error("aux before active");
	AST_STEP: assert property (spreadEnable && $past(spreadEnable) && $changed(freqCode) |->
		freqCode == $past(freqCode) + 4'h1 || freqCode == $past(freqCode) - 4'h1)
		else $error("freq jump");
endmodule : regprot_monitor
bind regulator_protect_and_reset_ctrl regprot_monitor mon (.ref_clk, .reset, .resetTrigger,
	.watchdog_trigger_in, .boostWindowFault, .boostOvertemp, .boostEnableWrite, .linregOvertemp,
	.linregWindowFault, .linregOvervoltage, .threshold_check_mode, .rampMode, .activeMode,
	.spreadEnable, .freqCode,
	.boostRunning, .boostFailFlag, .boost_overtemp_flag, .linregRunning, .linreg_failure_flag,
	.linreg_overtemp_flag, .external_protection_switch, .errorRequest, .useAuxSupply,
	.processor_reset_out_n, .peripheral_reset_out_n);

// [sim/power_stage_model.sv]
`timescale 1ns/1ns
module power_stage_model (
	input logic ref_clk,
	input logic wdRequest,
	output logic oscTick,
	output logic mainPwm,
	output logic secondPwm,
	output logic thirdPwm,
	output logic boostPwm,
	output logic watchdog_trigger_in
);
	int phase = 0;
	int slot = 0;
	// Four clocks per oscillator period, ten periods per main cycle.
	always @(negedge ref_clk)
	begin
		phase <= (phase + 1) % 4;
		if (phase == 3)
			slot <= (slot + 1) % 10;
	end
	assign oscTick = (phase == 0);
	assign mainPwm = (slot < 5);
	assign thirdPwm = (slot % 2 == 0);
	assign boostPwm = (slot % 2 == 0);
	assign secondPwm = (slot % 2 == 1);
	assign watchdog_trigger_in = wdRequest;
endmodule : power_stage_model

// [sim/regulator_protect_and_reset_ctrl_tb.sv]
`timescale 1ns/1ns
module regulator_protect_and_reset_ctrl_tb;
	logic ref_clk = 0;
	logic reset = 1;
	logic wdRequest = 0;
	logic oscTick, mainPwm, secondPwm, thirdPwm, boostPwm, watchdog_trigger_in;
	logic lowLoad = 0, secondHsLimit = 0, thirdHsLimit = 0, secondLsLimit = 0, thirdLsLimit = 0;
	logic secondLsEarly = 0, thirdLsEarly = 0, boostLimit = 0, boostWindowFault = 0;
	logic boostOvertemp = 0, boostEnableWrite = 0, linregOvertemp = 0, linregWindowFault = 0;
	logic linregOvervoltage = 0, linregEnableWrite = 0, threshold_check_mode = 0, rampMode = 0;
	logic activeMode = 0, spreadEnable = 0, triangleMode = 0, resetTrigger = 0;
	logic [15:0] auxSupplyMv = 16'h0000;
	logic secondHsOn, secondLsOn, thirdHsOn, thirdLsOn, boostSwitchOn, boostRunning;
	logic boostFailFlag, boost_overtemp_flag, linregRunning, linreg_failure_flag;
	logic linreg_overtemp_flag, external_protection_switch, errorRequest, useAuxSupply;
	logic [3:0] freqCode;
	logic processor_reset_out_n, peripheral_reset_out_n;
	int num_errors = 0;
	int tests_run = 0;
	int seed = 7;
	int m[6] = '{default: 0};
	int seq[10] = '{2, 0, 2, 1, 2, 5, 3, 5, 4, 5};
	regulator_protect_and_reset_ctrl dut (.*);
	power_stage_model psm (.*);
	initial forever #10 ref_clk = ~ref_clk;
	task automatic final_report();
		if (num_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	task automatic chk(input logic [15:0] got, input int exp, input string what);
		tests_run++;
		if (got !== exp[15:0])
		begin
			num_errors++;
			$display("FAIL %0t %s", $time, what);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	task automatic release_seq();
		int n = 0;
		while (processor_reset_out_n !== 1'b1 && n < 2000)
		begin
			cyc(1);
			n++;
		end
		chk(n >= regprot_pkg::RESET_HOLD_CYCLES - 3, 1, "hold");
		chk(n <= regprot_pkg::RESET_HOLD_CYCLES + 2, 1, "hold");
		cyc(20);
		chk(peripheral_reset_out_n, 0, "latched");
		wdRequest = 1;
		cyc(5);
		chk(peripheral_reset_out_n, 1, "released");
	endtask : release_seq
	// Checks the gate commands against the converter levels while no limit is active.
	task automatic steady(input int n);
		repeat (n)
		begin
			lowLoad = 1'($random(seed));
			cyc(1);
			chk({secondHsOn, secondLsOn, thirdHsOn, thirdLsOn},
				{secondPwm, !secondPwm, thirdPwm, !thirdPwm}, "gates");
			chk(boostSwitchOn, boostPwm && m[2] != 0 && !lowLoad, "boost gate");
		end
		cyc(1);
		lowLoad = 0;
	endtask : steady
	// Drives one fault or enable pulse and updates the flag model alongside.
	task automatic hit(input int k);
		int e = 0;
		int b = (k < 3) ? 0 : 3;
		logic [5:0] got;
		{boostWindowFault, boostOvertemp, boostEnableWrite, linregWindowFault, linregOvertemp,
			linregEnableWrite} = 6'h20 >> k;
		if (k - b < 2)
		begin
			m[k] = 1;
			m[b + 2] = 0;
		end
		else if (m[b + 1] == 0)
		begin
			m[b + 2] = 1;
			m[b] = 0;
		end
		cyc(1);
		{boostWindowFault, boostOvertemp, boostEnableWrite, linregWindowFault, linregOvertemp,
			linregEnableWrite} = 6'h00;
		foreach (m[i])
			e = e * 2 + m[i];
		cyc(1);
		got = {boostFailFlag, boost_overtemp_flag, boostRunning, linreg_failure_flag,
			linreg_overtemp_flag, linregRunning};
		chk(got, e, "flags");
		steady(6);
	endtask : hit
	task automatic spread(input int triMode);
		int q[$];
		int d;
		int lo = 15;
		triangleMode = triMode[0];
		spreadEnable = 1;
		repeat (60)
		begin
			repeat (40)
			begin
				cyc(1);
				{lowLoad, thirdHsLimit, thirdLsLimit, thirdLsEarly, boostLimit} = 5'($random(seed));
			end
			chk(freqCode <= regprot_pkg::FREQ_CODE_MAX, 1, "code range");
			q.push_back(int'(freqCode));
		end
		spreadEnable = 0;
		cyc(1);
		foreach (q[i])
		begin
			if (q[i] < lo)
				lo = q[i];
			d = (i > 0) ? q[i] - q[i - 1] : 1;
			chk(d inside {-1, 0, 1} && !(triMode != 0 && d == 0), 1, "step");
		end
		chk(triMode != 0 ? lo : 0, 0, "sweep");
	endtask : spread
	initial
	begin
		#400000;
		$display("FAIL %0t timeout", $time);
		num_errors++;
		final_report();
	end
	initial
	begin
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(processor_reset_out_n | peripheral_reset_out_n, 0, "reset outs");
		chk(freqCode, regprot_pkg::FREQ_CODE_RESET, "code reset");
		reset = 0;
		release_seq();
		activeMode = 1;
		foreach (seq[i])
			hit(seq[i]);
		for (int i = 0; i < 2; i++)
		begin
			{threshold_check_mode, rampMode} = 2'h1 << i;
			linregOvervoltage = 1;
			cyc(1);
			chk({external_protection_switch, errorRequest}, 1, "overvoltage");
			linregOvervoltage = 0;
			cyc(2);
			chk({external_protection_switch, errorRequest}, 2, "recovered");
		end
		auxSupplyMv = regprot_pkg::AUX_ON_MV + 16'h0001 + (16'($random(seed)) & 16'h0FFF);
		cyc(2);
		chk(useAuxSupply, 1, "aux on");
		auxSupplyMv = regprot_pkg::AUX_OFF_MV + 16'h0001 + (16'($random(seed)) & 16'h007F);
		cyc(2);
		chk(useAuxSupply, 1, "aux hold");
		auxSupplyMv = regprot_pkg::AUX_OFF_MV - 16'h0064;
		cyc(2);
		chk(useAuxSupply, 0, "aux off");
		secondHsLimit = 1;
		cyc(64);
		secondHsLimit = 0;
		repeat (80)
		begin
			cyc(1);
			chk(secondHsOn, 0, "blanked");
		end
		for (int n = 0; n < 300 && secondHsOn !== 1'b1; n++)
			cyc(1);
		chk(secondHsOn, 1, "unblanked");
		{secondLsLimit, secondLsEarly} = 2'h3;
		cyc(8);
		{secondLsLimit, secondLsEarly} = 2'h0;
		repeat (80)
		begin
			cyc(1);
			chk(secondHsOn | secondLsOn, 0, "both off");
		end
		spread(1);
		spread(0);
		wdRequest = 0;
		resetTrigger = 1;
		cyc(1);
		resetTrigger = 0;
		cyc(1);
		chk(processor_reset_out_n | peripheral_reset_out_n, 0, "trigger");
		release_seq();
		final_report();
	end
endmodule : regulator_protect_and_reset_ctrl_tb
